//--- rtl/itsq_regs.sv
`timescale 1ns/1ps
`include "itsq_consts.svh"

// Operation
// - set tx complete flag at frame end
// - status register read clears tx complete
// - interrupt only when matching enable set
// - tx buffer low flag, read clears
// - rx buffer high flag, read clears
// - rx frame end flag on closing flag
// - rx frame end cleared by read, resets
// - q nibble lsb first, every fifth frame
// - hardware clears enflg when nibble taken
// - done bit high until new word loaded or master soft reset
// - q sync needs syncs and flips five apart
// - q sync rises bit 15, drops on loss
// - remote loop returns b1/b2 to network
// - remote d loop returns d to network
// - local b2 loop to terminal, ones out
// - local b1 loop to terminal, ones out
// - local d loop to terminal, ones out
// - force ones replaces b channel traffic
// - b2 local loop, force ones default one
// - rx soft reset clears rx flags
// - master soft reset keeps control registers
module itsq_regs
  import itsq_pkg::*;
#(
  parameter int MF_FRAMES = `ITSQ_MF_FRAMES,
  parameter int Q_SPACING = `ITSQ_Q_SPACING,
  parameter int Q_BITS = `ITSQ_Q_BITS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire itsq_evt_s hdlc_evt,
  input wire itsq_frm_s frm,
  input wire itsq_lane_s line_rx,
  input wire logic terminal_b1_in,
  input wire logic terminal_b2_in,
  input wire logic hdlc_tx_d,
  output itsq_lane_s line_tx,
  output itsq_lane_s terminal_rx_out,
  output logic q_tx_bit,
  output logic q_tx_valid,
  output logic irq,
  output logic hdlc_reset,
  output logic rx_reset
);
  localparam int SW = $clog2(Q_BITS);
  localparam int PW = $clog2(Q_SPACING + 1);

  // refuse shapes the slot counters or the four-bit nibble field cannot serve
  if (Q_BITS != 4 || Q_SPACING < 2 || MF_FRAMES != Q_SPACING * Q_BITS) begin : g_chk
    $error("itsq_regs: multiframe shape unsupported");
  end

  // address decode, shared by read and write paths
  function automatic itsq_sel_e dec(input logic [11:0] a);
    itsq_sel_e s;
    s = ITSQ_SEL_NONE;
    if (a == `ITSQ_ADDR_STAT) begin
      s = ITSQ_SEL_STAT;
    end else if (a == `ITSQ_ADDR_QCTL) begin
      s = ITSQ_SEL_QCTL;
    end else if (a == `ITSQ_ADDR_LOOP) begin
      s = ITSQ_SEL_LOOP;
    end else if (a == `ITSQ_ADDR_IEN) begin
      s = ITSQ_SEL_IEN;
    end else if (a == `ITSQ_ADDR_SRST) begin
      s = ITSQ_SEL_SRST;
    end
    return s;
  endfunction

  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [3:0] flags_q, flags_d;
  logic [3:0] ien_q, ien_d;
  logic [7:0] loop_q, loop_d;
  logic irq_q, irq_d;
  logic hrst_q, hrst_d;
  logic rrst_q, rrst_d;
  logic [Q_BITS-1:0] qdata_q, qdata_d;
  logic [Q_BITS-1:0] qsh_q, qsh_d;
  logic enflg_q, enflg_d;
  logic doneq_q, doneq_d;
  itsq_qtx_e qst_q, qst_d;
  logic [PW-1:0] phase_q, phase_d;
  logic [SW-1:0] slot_q, slot_d;
  logic qbit_q, qbit_d;
  logic qval_q, qval_d;
  logic [PW-1:0] gap_q, gap_d;
  logic cand_q, cand_d;
  logic qse_q, qse_d;
  itsq_lane_s ltx_q, ltx_d;
  itsq_lane_s trx_q, trx_d;

  logic setup, wr_done, rd_done;
  itsq_sel_e sel;
  logic [3:0] rd_clr;
  logic [3:0] evt;

  // ready comes one cycle after setup: every access has exactly one wait-free access cycle
  assign setup = psel && !penable;
  assign wr_done = psel && penable && pready_q && pwrite;
  assign rd_done = psel && penable && pready_q && !pwrite;
  assign sel = dec(paddr);
  assign evt = {hdlc_evt.rx_end, hdlc_evt.rx_high, hdlc_evt.tx_low, hdlc_evt.tx_done};

  // apb slave: read data captured in setup so the access cycle is stable
  always_comb begin
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (setup) begin
      pready_d = 1'b1;
      pslverr_d = (sel == ITSQ_SEL_NONE);
      prdata_d = 32'h0000_0000;
      if (sel == ITSQ_SEL_STAT) begin
        prdata_d[7:4] = flags_q;
      end else if (sel == ITSQ_SEL_QCTL) begin
        prdata_d[3:0] = qdata_q;
        prdata_d[`ITSQ_Q_ENFLG] = enflg_q;
        prdata_d[`ITSQ_Q_DONEQ] = doneq_q;
        prdata_d[`ITSQ_Q_SYNC] = qse_q;
      end else if (sel == ITSQ_SEL_LOOP) begin
        prdata_d[7:0] = loop_q;
      end else if (sel == ITSQ_SEL_IEN) begin
        prdata_d[7:4] = ien_q;
      end
    end
  end

  // only the bits the host actually saw are cleared, so a late event survives
  assign rd_clr = (rd_done && sel == ITSQ_SEL_STAT) ? prdata_q[7:4] : 4'h0;

  // status flags, enables, soft resets and interrupt
  always_comb begin
    flags_d = flags_q;
    ien_d = ien_q;
    loop_d = loop_q;
    hrst_d = 1'b0;
    rrst_d = 1'b0;
    flags_d = flags_d & ~rd_clr;
    if (hrst_q) begin
      flags_d = `ITSQ_STAT_RST;
    end
    if (rrst_q) begin
      flags_d[`ITSQ_ST_RXHIGH-4] = 1'b0;
      flags_d[`ITSQ_ST_RXEND-4] = 1'b0;
    end
    flags_d = flags_d | evt;
    if (wr_done) begin
      if (sel == ITSQ_SEL_LOOP) begin
        loop_d = pwdata[7:0];
      end else if (sel == ITSQ_SEL_IEN) begin
        ien_d = pwdata[7:4];
      end else if (sel == ITSQ_SEL_SRST) begin
        hrst_d = pwdata[`ITSQ_SR_MASTER];
        rrst_d = pwdata[`ITSQ_SR_RX] | pwdata[`ITSQ_SR_MASTER];
      end
    end
    irq_d = |(flags_d & ien_d);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flags_q <= `ITSQ_STAT_RST;
      ien_q <= `ITSQ_IEN_RST;
      loop_q <= `ITSQ_LOOP_RST;
      irq_q <= 1'b0;
      hrst_q <= 1'b0;
      rrst_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      ien_q <= ien_d;
      loop_q <= loop_d;
      irq_q <= irq_d;
      hrst_q <= hrst_d;
      rrst_q <= rrst_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // q nibble transmit: one bit at the first frame of each five
  always_comb begin
    qdata_d = qdata_q;
    qsh_d = qsh_q;
    enflg_d = enflg_q;
    doneq_d = doneq_q;
    qst_d = qst_q;
    phase_d = phase_q;
    slot_d = slot_q;
    qbit_d = qbit_q;
    qval_d = 1'b0;
    if (frm.frame_strobe) begin
      if (frm.mf_start) begin
        phase_d = '0;
        slot_d = '0;
        qst_d = ITSQ_QTX_IDLE;
        if (enflg_q) begin
          enflg_d = 1'b0;
          qsh_d = qdata_q;
          qst_d = ITSQ_QTX_SEND;
          qbit_d = qdata_q[0];
          qval_d = 1'b1;
        end
      end else if (qst_q == ITSQ_QTX_SEND) begin
        if (phase_q == PW'(Q_SPACING - 1)) begin
          phase_d = '0;
          slot_d = slot_q + 1'b1;
          qbit_d = qsh_q[slot_d];
          qval_d = 1'b1;
          if (slot_d == SW'(Q_BITS - 1)) begin
            doneq_d = 1'b1;
            qst_d = ITSQ_QTX_IDLE;
          end
        end else begin
          phase_d = phase_q + 1'b1;
        end
      end
    end
    if (wr_done && sel == ITSQ_SEL_QCTL && pwdata[`ITSQ_Q_ENFLG]) begin
      qdata_d = pwdata[3:0];
      enflg_d = 1'b1;
      doneq_d = 1'b0;
    end
    if (hrst_q) begin
      qst_d = ITSQ_QTX_IDLE;
      doneq_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      qdata_q <= '0;
      qsh_q <= '0;
      enflg_q <= 1'b0;
      doneq_q <= 1'b0;
      qst_q <= ITSQ_QTX_IDLE;
      phase_q <= '0;
      slot_q <= '0;
      qbit_q <= 1'b1;
      qval_q <= 1'b0;
    end else begin
      qdata_q <= qdata_d;
      qsh_q <= qsh_d;
      enflg_q <= enflg_d;
      doneq_q <= doneq_d;
      qst_q <= qst_d;
      phase_q <= phase_d;
      slot_q <= slot_d;
      qbit_q <= qbit_d;
      qval_q <= qval_d;
    end
  end

  // q sync: flipped frames must recur exactly every fifth frame
  always_comb begin
    gap_d = gap_q;
    cand_d = cand_q;
    qse_d = qse_q;
    if (frm.frame_strobe) begin
      if (frm.fa_n_flip) begin
        cand_d = (gap_q == PW'(Q_SPACING - 1));
        gap_d = '0;
      end else begin
        if (gap_q >= PW'(Q_SPACING - 1)) begin
          // a missed flip breaks the pattern
          cand_d = 1'b0;
        end
        if (gap_q != PW'(Q_SPACING)) begin
          gap_d = gap_q + 1'b1;
        end
      end
    end
    if (frm.bit15_end) begin
      qse_d = cand_d;
    end
    if (!frm.frame_sync || !frm.mbit_sync || hrst_q) begin
      qse_d = 1'b0;
      cand_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gap_q <= '0;
      cand_q <= 1'b0;
      qse_q <= 1'b0;
    end else begin
      gap_q <= gap_d;
      cand_q <= cand_d;
      qse_q <= qse_d;
    end
  end

  // loopback and force-ones steering, one registered stage each way
  always_comb begin
    ltx_d.b2 = terminal_b2_in;
    ltx_d.b1 = terminal_b1_in;
    ltx_d.d = hdlc_tx_d;
    trx_d = line_rx;
    if (loop_q[`ITSQ_LB_REM_B2]) begin
      ltx_d.b2 = line_rx.b2;
    end
    if (loop_q[`ITSQ_LB_REM_B1]) begin
      ltx_d.b1 = line_rx.b1;
    end
    if (loop_q[`ITSQ_LB_REM_D]) begin
      ltx_d.d = line_rx.d;
    end
    if (loop_q[`ITSQ_LB_LOC_B2]) begin
      trx_d.b2 = terminal_b2_in;
      ltx_d.b2 = 1'b1;
    end
    if (loop_q[`ITSQ_LB_LOC_B1]) begin
      trx_d.b1 = terminal_b1_in;
      ltx_d.b1 = 1'b1;
    end
    if (loop_q[`ITSQ_LB_LOC_D]) begin
      trx_d.d = hdlc_tx_d;
      ltx_d.d = 1'b1;
    end
    if (loop_q[`ITSQ_LB_ONES_B2]) begin
      ltx_d.b2 = 1'b1;
    end
    if (loop_q[`ITSQ_LB_ONES_B1]) begin
      ltx_d.b1 = 1'b1;
    end
  end

  // idle line is marks, so reset drives ones
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ltx_q <= 3'b111;
      trx_q <= 3'b111;
    end else begin
      ltx_q <= ltx_d;
      trx_q <= trx_d;
    end
  end

  // every output straight from a flop
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign line_tx = ltx_q;
  assign terminal_rx_out = trx_q;
  assign q_tx_bit = qbit_q;
  assign q_tx_valid = qval_q;
  assign irq = irq_q;
  assign hdlc_reset = hrst_q;
  assign rx_reset = rrst_q;
endmodule // itsq_regs

//--- include/itsq_consts.svh
`ifndef ITSQ_CONSTS_SVH
`define ITSQ_CONSTS_SVH
// register byte offsets
`define ITSQ_ADDR_STAT 12'h000
`define ITSQ_ADDR_QCTL 12'h004
`define ITSQ_ADDR_LOOP 12'h008
`define ITSQ_ADDR_IEN 12'h00c
`define ITSQ_ADDR_SRST 12'h010
// status register bits
`define ITSQ_ST_TXDONE 4
`define ITSQ_ST_TXLOW 5
`define ITSQ_ST_RXHIGH 6
`define ITSQ_ST_RXEND 7
// q channel register fields
`define ITSQ_Q_DATA_LSB 0
`define ITSQ_Q_ENFLG 4
`define ITSQ_Q_DONEQ 5
`define ITSQ_Q_SYNC 7
// loopback register bits
`define ITSQ_LB_REM_B2 0
`define ITSQ_LB_REM_B1 1
`define ITSQ_LB_REM_D 2
`define ITSQ_LB_LOC_B2 3
`define ITSQ_LB_LOC_B1 4
`define ITSQ_LB_LOC_D 5
`define ITSQ_LB_ONES_B2 6
`define ITSQ_LB_ONES_B1 7
// soft reset register bits
`define ITSQ_SR_MASTER 0
`define ITSQ_SR_RX 1
// reset values
`define ITSQ_STAT_RST 4'h0
`define ITSQ_IEN_RST 4'h0
`define ITSQ_LOOP_RST 8'h48
// multiframe timing, in frames and bits
`define ITSQ_MF_FRAMES 20
`define ITSQ_Q_SPACING 5
`define ITSQ_Q_BITS 4
`endif

//--- include/itsq_pkg.sv
package itsq_pkg;
  // one bit of each line channel
  typedef struct packed {
    logic b1;
    logic b2;
    logic d;
  } itsq_lane_s;
  // hdlc events, one-cycle pulses
  typedef struct packed {
    logic tx_done;
    logic tx_low;
    logic rx_high;
    logic rx_end;
  } itsq_evt_s;
  // receive framing information
  typedef struct packed {
    logic frame_strobe;
    logic mf_start;
    logic frame_sync;
    logic mbit_sync;
    logic fa_n_flip;
    logic bit15_end;
  } itsq_frm_s;
  typedef enum logic [0:0] {
    ITSQ_QTX_IDLE = 1'b0,
    ITSQ_QTX_SEND = 1'b1
  } itsq_qtx_e;
  typedef enum logic [2:0] {
    ITSQ_SEL_NONE = 3'b000,
    ITSQ_SEL_STAT = 3'b001,
    ITSQ_SEL_QCTL = 3'b010,
    ITSQ_SEL_LOOP = 3'b011,
    ITSQ_SEL_IEN = 3'b100,
    ITSQ_SEL_SRST = 3'b101
  } itsq_sel_e;
endpackage

//--- testbench/itsq_regs_properties.sv
`timescale 1ns/1ps
`include "itsq_consts.svh"
module itsq_regs_props
  import itsq_pkg::*;
#(
  parameter int MF_FRAMES = 20,
  parameter int Q_SPACING = 5,
  parameter int Q_BITS = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire itsq_lane_s line_rx,
  input wire logic terminal_b1_in,
  input wire logic terminal_b2_in,
  input wire logic hdlc_tx_d,
  input wire itsq_lane_s line_tx,
  input wire itsq_lane_s terminal_rx_out
);
  logic [7:0] lp_q;
  logic [7:0] lp_d;
  // shadow of the loop register, updated at the same edge as the slave
  always_comb begin
    lp_d = lp_q;
    if (psel && penable && pready && pwrite && paddr == `ITSQ_ADDR_LOOP) begin
      lp_d = pwdata[7:0];
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lp_q <= `ITSQ_LOOP_RST;
    end else begin
      lp_q <= lp_d;
    end
  end
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  AST_ANSWER: assert property (psel && !penable |=> pready && penable)
    else $error("no answer after setup");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_B2_ONES: assert property (lp_q[3] || lp_q[6] |=> line_tx.b2)
    else $error("b2 to network not ones");
  AST_B1_ONES: assert property (lp_q[4] || lp_q[7] |=> line_tx.b1)
    else $error("b1 to network not ones");
  AST_D_ONES: assert property (lp_q[5] |=> line_tx.d)
    else $error("d to network not ones");
  AST_LOC_B2: assert property (lp_q[3] && !lp_q[6] |=> terminal_rx_out.b2 == $past(terminal_b2_in))
    else $error("b2 local loop wrong");
  AST_LOC_B1: assert property (lp_q[4] && !lp_q[7] |=> terminal_rx_out.b1 == $past(terminal_b1_in))
    else $error("b1 local loop wrong");
  AST_LOC_D: assert property (lp_q[5] |=> terminal_rx_out.d == $past(hdlc_tx_d))
    else $error("d local loop wrong");
  AST_REM_B2: assert property (lp_q[0] && !lp_q[3] && !lp_q[6] |=> line_tx.b2 == $past(line_rx.b2))
    else $error("b2 remote loop wrong");
  AST_REM_D: assert property (lp_q[2] && !lp_q[5] |=> line_tx.d == $past(line_rx.d))
    else $error("d remote loop wrong");
  AST_NORMAL_B1: assert property (lp_q[7:6] == 2'h0 && !lp_q[1] && !lp_q[4] |=> line_tx.b1 == $past(terminal_b1_in))
    else $error("b1 normal traffic wrong");
endmodule // itsq_regs_props

bind itsq_regs itsq_regs_props #(.MF_FRAMES(MF_FRAMES), .Q_SPACING(Q_SPACING), .Q_BITS(Q_BITS))
  itsq_regs_props_i (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .line_rx(line_rx), .terminal_b1_in(terminal_b1_in), .terminal_b2_in(terminal_b2_in),
  .hdlc_tx_d(hdlc_tx_d), .line_tx(line_tx), .terminal_rx_out(terminal_rx_out));

//--- testbench/itsq_nt_model.sv
`timescale 1ns/1ps
module itsq_nt_model
  import itsq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sync_on,
  output itsq_frm_s frm,
  output itsq_lane_s line_rx
);
  logic [1:0] cyc_q, cyc_d;
  logic [4:0] frm_q, frm_d;
  logic [2:0] pat_q, pat_d;
  // four clocks a frame keeps a multiframe short
  always_comb begin
    cyc_d = cyc_q + 2'h1;
    pat_d = pat_q + 3'h3;
    frm_d = frm_q;
    if (cyc_q == 2'h3) begin
      frm_d = (frm_q == 5'h13) ? 5'h00 : frm_q + 5'h01;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cyc_q <= '0;
      frm_q <= '0;
      pat_q <= '0;
    end else begin
      cyc_q <= cyc_d;
      frm_q <= frm_d;
      pat_q <= pat_d;
    end
  end
  // line bits change every clock, so a stale path shows up
  assign line_rx = itsq_lane_s'(pat_q);
  assign frm.frame_strobe = cyc_q == 2'h3;
  assign frm.mf_start = cyc_q == 2'h3 && frm_q == 5'h00;
  assign frm.frame_sync = sync_on;
  assign frm.mbit_sync = sync_on;
  // flipped pair every fifth frame
  assign frm.fa_n_flip = cyc_q == 2'h3 && frm_q % 5 == 0;
  assign frm.bit15_end = cyc_q == 2'h0;
endmodule // itsq_nt_model

//--- testbench/itsq_regs_tb.sv
`timescale 1ns/1ps
`include "itsq_consts.svh"
module itsq_regs_tb
  import itsq_pkg::*;
;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, sync_on = 0;
  logic terminal_b1_in = 0, terminal_b2_in = 0, hdlc_tx_d = 0, errv, gap_bad = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, irq, q_tx_bit, q_tx_valid, hdlc_reset, rx_reset;
  logic [3:0] qb = '0;
  logic [7:0] lv [5] = '{8'h48, 8'h07, 8'h38, 8'h00, 8'hc0};
  itsq_evt_s hdlc_evt = '0, acc_ev = '0;
  itsq_frm_s frm;
  itsq_lane_s line_rx, line_tx, terminal_rx_out;
  int error_cnt = 0, samples_checked = 0, sc = 0, qn = 0, rxp = 0, hrp = 0;

  itsq_regs itsq_regs_i (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hdlc_evt(hdlc_evt), .frm(frm), .line_rx(line_rx),
    .terminal_b1_in(terminal_b1_in), .terminal_b2_in(terminal_b2_in), .hdlc_tx_d(hdlc_tx_d),
    .line_tx(line_tx), .terminal_rx_out(terminal_rx_out), .q_tx_bit(q_tx_bit),
    .q_tx_valid(q_tx_valid), .irq(irq), .hdlc_reset(hdlc_reset), .rx_reset(rx_reset));
  itsq_nt_model itsq_nt_model_i (.sys_clk(sys_clk), .rst(rst), .sync_on(sync_on),
    .frm(frm), .line_rx(line_rx));

  always #4 sys_clk = ~sys_clk;

  // terminal bits keep moving so loop paths see live data
  always @(posedge sys_clk) begin
    {terminal_b1_in, terminal_b2_in, hdlc_tx_d} <= {hdlc_tx_d, terminal_b1_in, ~terminal_b2_in};
  end

  // gather q bits and count frames between them
  always @(posedge sys_clk) begin
    if (frm.frame_strobe === 1'b1) sc++;
    if (q_tx_valid === 1'b1) begin
      qb = {q_tx_bit, qb[3:1]};
      qn++;
      if (qn > 1 && sc != 5) gap_bad = 1;
      sc = 0;
    end
  end

  // count soft reset pulses; a stuck pulse shows up as an extra count
  always @(posedge sys_clk) begin
    if (rx_reset === 1'b1) rxp++;
    if (hdlc_reset === 1'b1) hrp++;
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  // one apb transfer; an idle edge after it so psel never retoggles in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    hdlc_evt <= acc_ev;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    errv = pslverr;
    hdlc_evt <= '0;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] e, input string n);
    apb(0, a, 0);
    chk(n, e, rd);
  endtask

  task ev(input logic [3:0] e);
    hdlc_evt <= itsq_evt_s'(e);
    @(posedge sys_clk);
    hdlc_evt <= '0;
    @(posedge sys_clk);
    @(posedge sys_clk);
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 0;
    rdc(`ITSQ_ADDR_LOOP, 32'h48, "loop_rst");
    rdc(12'h0ff, 32'h0, "unmapped");
    chk("slverr", 32'h1, errv);
    $display("reset test done");
    for (int i = 4; i < 8; i++) begin
      ev(4'h8 >> (i - 4));
      rdc(`ITSQ_ADDR_STAT, 32'h1 << i, "flag_set");
      rdc(`ITSQ_ADDR_STAT, 32'h0, "flag_clr");
    end
    ev(4'h8);
    chk("irq_masked", 32'h0, irq);
    rdc(`ITSQ_ADDR_STAT, 32'h10, "flag_unmasked");
    apb(1, `ITSQ_ADDR_IEN, 32'hf0);
    ev(4'h8);
    chk("irq_on", 32'h1, irq);
    rdc(`ITSQ_ADDR_STAT, 32'h10, "flag_irq");
    @(posedge sys_clk);
    chk("irq_off", 32'h0, irq);
    // flag already set, so the clearing read and the new event meet
    ev(4'h8);
    acc_ev = itsq_evt_s'(4'h8);
    rdc(`ITSQ_ADDR_STAT, 32'h10, "race_rd");
    acc_ev = '0;
    rdc(`ITSQ_ADDR_STAT, 32'h10, "race_kept");
    // tx done must survive a receiver-only reset
    ev(4'hb);
    apb(1, `ITSQ_ADDR_SRST, 32'h2);
    rdc(`ITSQ_ADDR_STAT, 32'h10, "rx_srst");
    chk("rx_pulse", 32'h1, rxp);
    chk("hdlc_pulse", 32'h0, hrp);
    $display("status test done");
    for (int k = 0; k < 100 && frm.mf_start !== 1'b1; k++) @(posedge sys_clk);
    // nibble 0xa with enable high, bit six zero
    apb(1, `ITSQ_ADDR_QCTL, 32'h1a);
    apb(0, `ITSQ_ADDR_QCTL, 0);
    chk("q_load", 32'h10, rd & 32'h30);
    for (int k = 0; k < 300 && qn < 4; k++) @(posedge sys_clk);
    chk("q_bits", 32'ha, qb);
    chk("q_gap", 32'h0, gap_bad);
    apb(0, `ITSQ_ADDR_QCTL, 0);
    chk("q_done", 32'h20, rd & 32'h30);
    sync_on <= 1;
    repeat (60) @(posedge sys_clk);
    apb(0, `ITSQ_ADDR_QCTL, 0);
    chk("qsync_on", 32'h80, rd & 32'h80);
    sync_on <= 0;
    repeat (2) @(posedge sys_clk);
    apb(0, `ITSQ_ADDR_QCTL, 0);
    chk("qsync_off", 32'h0, rd & 32'h80);
    $display("q test done");
    // loop path checking sits outside this block, in the bound properties
    foreach (lv[i]) begin
      apb(1, `ITSQ_ADDR_LOOP, {24'h0, lv[i]});
      rdc(`ITSQ_ADDR_LOOP, {24'h0, lv[i]}, "loop_rw");
      repeat (20) @(posedge sys_clk);
    end
    ev(4'h8);
    apb(1, `ITSQ_ADDR_SRST, 32'h1);
    rdc(`ITSQ_ADDR_STAT, 32'h0, "msr_flags");
    rdc(`ITSQ_ADDR_LOOP, 32'hc0, "msr_loop");
    chk("msr_rx_pulse", 32'h2, rxp);
    chk("msr_hdlc_pulse", 32'h1, hrp);
    rdc(`ITSQ_ADDR_IEN, 32'hf0, "msr_ien");
    $display("loop test done");
    end_sim;
  end

  // the tests need about 500 clocks; the 20000-clock limit leaves wide margin
  initial begin
    #160000;
    error_cnt++;
    end_sim;
  end
endmodule // itsq_regs_tb
